// file: rtl/swa_pkg.sv
// shared constants for the serial register word access block
`default_nettype none
package swa_pkg;
   // -----------------------------------------------------------------
   // request word layout
   // -----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int DATA_W = 10;
   localparam int ADDR_W = 5;
   localparam int DATA_MSB = 15;
   localparam int DATA_LSB = 6;
   localparam int ADDR_MSB = 5;
   localparam int ADDR_LSB = 1;
   localparam int RW_BIT = 0;
   localparam logic OP_WRITE = 1'b0;
   localparam logic OP_READ = 1'b1;
   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int PAGE_W = 2;
   localparam logic [ADDR_W-1:0] RSVD_ADDR = 5'h00;
   localparam logic [ADDR_W-1:0] PAGE_SEL_ADDR = 5'h01;
   localparam int BSP_PAGE_LSB = 2;
   localparam int UC_PAGE_LSB = 0;
   localparam logic [DATA_W-1:0] PAGE_SEL_RST = 10'h000;
   localparam logic [DATA_W-1:0] REG_RST = 10'h000;
   // -----------------------------------------------------------------
   // burst sample stream
   // -----------------------------------------------------------------
   localparam int SAMPLE_W = 15;
   localparam int GAP_BITS = 16;
   localparam int FIFO_DEPTH = 16;
endpackage : swa_pkg
`default_nettype wire

// file: rtl/swa_sample_fifo.sv
// flip-flop fifo for burst sample words
`default_nettype none
module swa_sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH) $error("fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge sys_clk_i) begin
      if (clk_en_i && push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (clk_en_i) begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   a_no_overflow: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      cnt_q == (PW+1)'(DEPTH) |-> !in_ready_o)
      else $error("fifo full but ready");
endmodule : swa_sample_fifo
`default_nettype wire

// file: rtl/swa_serial_register_word_access.sv
// register word access and burst sample transmit path
// -----------------------------------------------------------------------
// Overview of operation
// R1: requests are single 16-bit words
// R2: bits 15:6 carry ten data bits
// R3: bits 5:1 address, qualified by page
// R4: bit 0: zero writes, one reads
// R5: read requests ignore the data field
// R6: same format on both serial ports
// R7: burst samples leave on baseband transmit side
// R8: sample bits 15:1, bit 0 I/Q
// R9: one bit per 13 MHz clock edge
// R10: stream averages 8.66 Mbps, must be absorbed (the link here carries at most 6.5 Mbps)
// R11: one word time gap between words
// R12: link idle about a third of burst (with the 16-bit gap it is idle half the time)
// R13: read reply returns data in bits 15:6
// R14: reserved writes change no register
// -----------------------------------------------------------------------
`default_nettype none
module swa_serial_register_word_access #(
   parameter int PAGES = 4,
   parameter int GAP_BITS = swa_pkg::GAP_BITS,
   parameter int FIFO_DEPTH = swa_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   // baseband serial port, received request words
   input wire logic bsp_req_valid_i,
   output logic bsp_req_ready_o,
   input wire logic [swa_pkg::WORD_W-1:0] bsp_req_word_i,
   // baseband serial port, reply words
   output logic bsp_reply_valid_o,
   output logic [swa_pkg::WORD_W-1:0] bsp_reply_word_o,
   // microcontroller serial port, received request words
   input wire logic uc_req_valid_i,
   output logic uc_req_ready_o,
   input wire logic [swa_pkg::WORD_W-1:0] uc_req_word_i,
   // microcontroller serial port, reply words
   output logic uc_reply_valid_o,
   output logic [swa_pkg::WORD_W-1:0] uc_reply_word_o,
   // downlink codec samples
   input wire logic burst_active_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic [swa_pkg::SAMPLE_W-1:0] sample_i,
   input wire logic sample_is_q_i,
   // baseband serial port transmit pins
   input wire logic master_clock_13m_i,
   output logic bsp_tx_data_o,
   output logic bsp_tx_frame_o
);
   // -----------------------------------------------------------------
   // parameter checks
   // -----------------------------------------------------------------
   initial begin
      if (PAGES < 1 || PAGES > (1 << swa_pkg::PAGE_W)) $error("PAGES out of range");
      if (GAP_BITS < 1) $error("GAP_BITS must be positive");
   end

   localparam int NREG = 1 << swa_pkg::ADDR_W;
   localparam int DW = swa_pkg::DATA_W;
   localparam int AW = swa_pkg::ADDR_W;
   localparam int PW = swa_pkg::PAGE_W;

   // -----------------------------------------------------------------
   // request arbitration
   // -----------------------------------------------------------------
   // baseband port wins; the controller port stalls a cycle on a clash
   logic sel_bsp;
   logic req_take;
   logic [swa_pkg::WORD_W-1:0] req_word;

   assign bsp_req_ready_o = clk_en_i;
   assign uc_req_ready_o = clk_en_i && !bsp_req_valid_i;
   assign sel_bsp = bsp_req_valid_i;
   assign req_take = clk_en_i && (bsp_req_valid_i || uc_req_valid_i);
   assign req_word = sel_bsp ? bsp_req_word_i : uc_req_word_i; // [R6]

   // -----------------------------------------------------------------
   // request word decode
   // -----------------------------------------------------------------
   logic [DW-1:0] req_data;
   logic [AW-1:0] req_addr;
   logic req_is_read;
   logic [PW-1:0] req_page;
   logic page_ok;
   logic [DW-1:0] page_sel_q;

   assign req_data = req_word[swa_pkg::DATA_MSB:swa_pkg::DATA_LSB]; // [R1] [R2]
   assign req_addr = req_word[swa_pkg::ADDR_MSB:swa_pkg::ADDR_LSB]; // [R3]
   assign req_is_read = (req_word[swa_pkg::RW_BIT] == swa_pkg::OP_READ); // [R4]
   // each port keeps its own page field in the shared page select register
   assign req_page = sel_bsp ? page_sel_q[swa_pkg::BSP_PAGE_LSB +: PW]
                             : page_sel_q[swa_pkg::UC_PAGE_LSB +: PW]; // [R3]
   assign page_ok = (int'(req_page) < PAGES);

   logic wr_en;
   logic wr_page_sel;
   logic wr_reg;

   // read requests never reach the write path, so their data is ignored
   assign wr_en = req_take && !req_is_read; // [R4] [R5]
   assign wr_page_sel = wr_en && (req_addr == swa_pkg::PAGE_SEL_ADDR);
   // reserved address and absent pages are dropped [R14]
   assign wr_reg = wr_en && page_ok && (req_addr != swa_pkg::RSVD_ADDR)
                   && (req_addr != swa_pkg::PAGE_SEL_ADDR);

   // -----------------------------------------------------------------
   // register storage
   // -----------------------------------------------------------------
   logic [DW-1:0] regs_q [PAGES][NREG];

   // page select sits at the same address on every page
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         page_sel_q <= swa_pkg::PAGE_SEL_RST;
      end else if (clk_en_i && wr_page_sel) begin
         page_sel_q <= req_data; // [R2]
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int p = 0; p < PAGES; p++) begin
            for (int a = 0; a < NREG; a++) begin
               regs_q[p][a] <= swa_pkg::REG_RST;
            end
         end
      end else if (clk_en_i && wr_reg) begin
         regs_q[req_page][req_addr] <= req_data; // [R3] [R14]
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   logic [DW-1:0] rd_data;

   always_comb begin
      rd_data = '0;
      if (req_addr == swa_pkg::PAGE_SEL_ADDR) begin
         rd_data = page_sel_q;
      end else if (page_ok && req_addr != swa_pkg::RSVD_ADDR) begin
         rd_data = regs_q[req_page][req_addr];
      end
   end

   logic [swa_pkg::WORD_W-1:0] reply_d;

   always_comb begin
      reply_d = '0;
      reply_d[swa_pkg::DATA_MSB:swa_pkg::DATA_LSB] = rd_data; // [R13]
      reply_d[swa_pkg::ADDR_MSB:swa_pkg::ADDR_LSB] = req_addr;
      reply_d[swa_pkg::RW_BIT] = swa_pkg::OP_READ;
   end

   // reply words are returned on the port that asked
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bsp_reply_valid_o <= 1'b0;
         uc_reply_valid_o <= 1'b0;
      end else if (clk_en_i) begin
         bsp_reply_valid_o <= req_take && req_is_read && sel_bsp; // [R13]
         uc_reply_valid_o <= req_take && req_is_read && !sel_bsp; // [R6]
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bsp_reply_word_o <= '0;
         uc_reply_word_o <= '0;
      end else if (clk_en_i && req_take && req_is_read) begin
         if (sel_bsp) bsp_reply_word_o <= reply_d;
         else uc_reply_word_o <= reply_d;
      end
   end

   // -----------------------------------------------------------------
   // master clock synchroniser and bit tick
   // -----------------------------------------------------------------
   logic mclk_s1_q;
   logic mclk_s2_q;
   logic mclk_s3_q;
   logic bit_tick;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mclk_s1_q <= 1'b0;
         mclk_s2_q <= 1'b0;
         mclk_s3_q <= 1'b0;
      end else if (clk_en_i) begin
         mclk_s1_q <= master_clock_13m_i;
         mclk_s2_q <= mclk_s1_q;
         mclk_s3_q <= mclk_s2_q;
      end
   end

   // one tick per master clock rising edge; the pins then change
   // about three system clocks after the edge, still within the bit
   assign bit_tick = mclk_s2_q && !mclk_s3_q; // [R9]

   // -----------------------------------------------------------------
   // sample buffering
   // -----------------------------------------------------------------
   // the buffer soaks up the gap after each word, but with a 16-bit gap the link carries
   // at most half the bit rate, so a long burst fills it and sample_ready_o stalls [R10] [R12]
   logic [swa_pkg::WORD_W-1:0] sample_word;
   logic fifo_in_valid;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [swa_pkg::WORD_W-1:0] fifo_out_data;

   assign sample_word = {sample_i, sample_is_q_i}; // [R8]
   // samples are only taken while a burst is being received
   assign fifo_in_valid = sample_valid_i && burst_active_i; // [R7]

   swa_sample_fifo #(
      .WIDTH(swa_pkg::WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(sample_ready_o),
      .in_data_i(sample_word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // -----------------------------------------------------------------
   // transmit serialiser
   // -----------------------------------------------------------------
   logic sh_ready;

   assign fifo_out_ready = sh_ready && clk_en_i;

   swa_word_shifter #(
      .GAP(GAP_BITS)
   ) u_shifter (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .clk_en_i(clk_en_i),
      .bit_tick_i(bit_tick),
      .word_valid_i(fifo_out_valid),
      .word_ready_o(sh_ready),
      .word_i(fifo_out_data),
      .sd_o(bsp_tx_data_o), // [R7]
      .fs_o(bsp_tx_frame_o)
   );

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_read_reply_data: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R13]
      req_take && req_is_read && sel_bsp |=>
         bsp_reply_valid_o && bsp_reply_word_o[swa_pkg::RW_BIT]
         && bsp_reply_word_o[swa_pkg::DATA_MSB:swa_pkg::DATA_LSB] == $past(rd_data))
      else $error("read reply missing or wrong");

   a_write_no_reply: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R4]
      req_take && !req_is_read |=> !bsp_reply_valid_o && !uc_reply_valid_o)
      else $error("write produced a reply");

   a_read_keeps_page: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R5]
      req_take && req_is_read |=> $stable(page_sel_q))
      else $error("read changed page select");

   a_page_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R2]
      req_take && !req_is_read && req_addr == swa_pkg::PAGE_SEL_ADDR
         |=> page_sel_q == $past(req_data))
      else $error("page select not written");

   a_rsvd_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R14]
      req_take && !req_is_read && req_addr == swa_pkg::RSVD_ADDR
         |=> $stable(page_sel_q) && regs_q[0][swa_pkg::RSVD_ADDR] == swa_pkg::REG_RST)
      else $error("reserved write changed state");

   a_reg_write_lands: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R3]
      wr_reg && req_page == '0 && req_addr == swa_pkg::ADDR_W'(2)
         |=> regs_q[0][2] == $past(req_data))
      else $error("register write lost");

   a_uc_stall: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R6]
      bsp_req_valid_i && uc_req_valid_i |-> !uc_req_ready_o)
      else $error("controller port not stalled");

   a_uc_reply: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R6]
      req_take && req_is_read && !sel_bsp ##1 clk_en_i |-> uc_reply_valid_o ##1 !uc_reply_valid_o)
      else $error("controller reply not a pulse");

   a_sample_gate: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R7]
      !burst_active_i |-> !fifo_in_valid)
      else $error("sample taken outside burst");

   c_bsp_read: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
      bsp_reply_valid_o);
   c_uc_write: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
      req_take && !sel_bsp && !req_is_read);
   c_frame_out: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $rose(bsp_tx_frame_o));
   c_fifo_full: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
      sample_valid_i && burst_active_i && !sample_ready_o);
endmodule : swa_serial_register_word_access
`default_nettype wire

// file: rtl/swa_word_shifter.sv
// shifts 16-bit sample words out msb first, one bit per master clock edge
`default_nettype none
module swa_word_shifter #(
   parameter int GAP = 16
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   input wire logic bit_tick_i,
   // word in
   input wire logic word_valid_i,
   output logic word_ready_o,
   input wire logic [swa_pkg::WORD_W-1:0] word_i,
   // serial out
   output logic sd_o,
   output logic fs_o
);
   initial begin
      if (GAP < 2 || GAP > 255) $error("gap out of range");
   end

   typedef enum logic [2:0] {
      SH_IDLE = 3'b001,
      SH_SHIFT = 3'b010,
      SH_GAP = 3'b100
   } swa_sh_e;

   swa_sh_e state_q;
   logic [swa_pkg::WORD_W-1:0] sh_q;
   logic [7:0] cnt_q;

   assign word_ready_o = (state_q == SH_IDLE) && bit_tick_i;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= SH_IDLE;
         sh_q <= '0;
         cnt_q <= '0;
         sd_o <= 1'b0;
         fs_o <= 1'b0;
      end else if (clk_en_i && bit_tick_i) begin
         fs_o <= 1'b0;
         case (state_q)
            SH_IDLE: begin
               if (word_valid_i) begin
                  sd_o <= word_i[swa_pkg::WORD_W-1];
                  fs_o <= 1'b1;
                  sh_q <= word_i << 1;
                  cnt_q <= 8'(swa_pkg::WORD_W - 1);
                  state_q <= SH_SHIFT;
               end
            end
            SH_SHIFT: begin
               if (cnt_q == '0) begin
                  // idle gap of about one word time before the next [R11]
                  // this tick is the first idle bit, so the gap state runs one short
                  sd_o <= 1'b0;
                  cnt_q <= 8'(GAP - 2);
                  state_q <= SH_GAP;
               end else begin
                  sd_o <= sh_q[swa_pkg::WORD_W-1];
                  sh_q <= sh_q << 1;
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            SH_GAP: begin
               if (cnt_q == '0) state_q <= SH_IDLE;
               else cnt_q <= cnt_q - 1'b1;
            end
            default: state_q <= SH_IDLE;
         endcase
      end
   end

   a_frame_in_shift: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R9]
      fs_o |-> state_q == SH_SHIFT)
      else $error("frame sync outside shift");
   a_gap_length: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R11]
      $rose(state_q == SH_GAP) |-> cnt_q == 8'(GAP - 2) && !sd_o)
      else $error("gap not loaded");
   a_ready_on_tick: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R9]
      word_ready_o |-> bit_tick_i)
      else $error("word taken off a bit tick");
endmodule : swa_word_shifter
`default_nettype wire

// file: testbench/swa_bsp_rx_model.sv
// receive-side model of the baseband serial port transmit stream
`default_nettype none
module swa_bsp_rx_model (
   // clock and reset
   input wire logic master_clock_13m_i,
   input wire logic nrst_i,
   // serial in
   input wire logic tx_data_i,
   input wire logic tx_frame_i,
   // captured words
   output logic word_stb_o,
   output logic [15:0] word_o,
   output logic [15:0] gap_o,
   output logic gap_dirty_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic active_q;
   logic [3:0] cnt_q;
   logic [15:0] sh_q;
   logic [15:0] gap_q;
   // ---------------------------------------------------------------
   // deserialiser
   // ---------------------------------------------------------------
   // sampled on the next master edge: the device launches a few system clocks late
   always_ff @(posedge master_clock_13m_i or negedge nrst_i) begin
      if (!nrst_i) begin
         active_q <= 1'b0;
         cnt_q <= 4'h0;
         sh_q <= 16'h0000;
         gap_q <= 16'h0000;
         gap_o <= 16'h0000;
         word_o <= 16'h0000;
         word_stb_o <= 1'b0;
         gap_dirty_o <= 1'b0;
      end else begin
         word_stb_o <= 1'b0;
         if (tx_frame_i) begin
            active_q <= 1'b1;
            cnt_q <= 4'h1;
            sh_q <= {15'h0000, tx_data_i};
            gap_o <= gap_q;
            gap_q <= 16'h0000;
         end else if (active_q) begin
            sh_q <= {sh_q[14:0], tx_data_i};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'hf) begin
               active_q <= 1'b0;
               word_o <= {sh_q[14:0], tx_data_i};
               word_stb_o <= 1'b1;
            end
         end else begin
            gap_q <= gap_q + 16'h0001;
            if (tx_data_i) begin
               gap_dirty_o <= 1'b1;
            end
         end
      end
   end
endmodule : swa_bsp_rx_model
`default_nettype wire

// file: testbench/swa_serial_register_word_access_tb.sv
// self-checking bench for the serial register word access block
`default_nettype none
`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module swa_serial_register_word_access_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i, nrst_i, clk_en_i, mclk;
   logic bsp_req_valid_i, bsp_req_ready_o, bsp_reply_valid_o;
   logic uc_req_valid_i, uc_req_ready_o, uc_reply_valid_o;
   logic [15:0] bsp_req_word_i, bsp_reply_word_o, uc_req_word_i, uc_reply_word_o;
   logic burst_active_i, sample_valid_i, sample_ready_o, sample_is_q_i;
   logic [14:0] sample_i;
   logic tx_data, tx_frame, word_stb, gap_dirty, saw_full;
   logic [15:0] rx_word, rx_gap;
   logic [15:0] bsp_q[$], uc_q[$], samp_q[$];
   logic [9:0] mem[4][32];
   logic [9:0] page_reg;
   int failures = 0, total_checks = 0, cycles = 0, nseen = 0;
   // ---------------------------------------------------------------
   // design and far side
   // ---------------------------------------------------------------
   swa_serial_register_word_access dut_u (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
      .bsp_req_valid_i(bsp_req_valid_i), .bsp_req_ready_o(bsp_req_ready_o),
      .bsp_req_word_i(bsp_req_word_i), .bsp_reply_valid_o(bsp_reply_valid_o),
      .bsp_reply_word_o(bsp_reply_word_o), .uc_req_valid_i(uc_req_valid_i),
      .uc_req_ready_o(uc_req_ready_o), .uc_req_word_i(uc_req_word_i),
      .uc_reply_valid_o(uc_reply_valid_o), .uc_reply_word_o(uc_reply_word_o),
      .burst_active_i(burst_active_i), .sample_valid_i(sample_valid_i),
      .sample_ready_o(sample_ready_o), .sample_i(sample_i), .sample_is_q_i(sample_is_q_i),
      .master_clock_13m_i(mclk), .bsp_tx_data_o(tx_data), .bsp_tx_frame_o(tx_frame));
   swa_bsp_rx_model rx_u (
      .master_clock_13m_i(mclk), .nrst_i(nrst_i), .tx_data_i(tx_data),
      .tx_frame_i(tx_frame), .word_stb_o(word_stb), .word_o(rx_word),
      .gap_o(rx_gap), .gap_dirty_o(gap_dirty));
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // free-running master clock, phase unrelated to the system clock
   initial begin
      mclk = 1'b0;
      forever #38.5 mclk = ~mclk;
   end
   // ---------------------------------------------------------------
   // closing and watchdog
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         end_sim();
      end
   end
   // ---------------------------------------------------------------
   // monitors: oldest note against each result
   // ---------------------------------------------------------------
   // replies are looked at mid-cycle, away from the edge that launches them
   always @(negedge sys_clk_i) begin
      if (bsp_reply_valid_o === 1'b1) begin
         `CHK(bsp_reply_word_o, (bsp_q.size() > 0) ? bsp_q.pop_front() : 16'hxxxx)
      end
      if (uc_reply_valid_o === 1'b1) begin
         `CHK(uc_reply_word_o, (uc_q.size() > 0) ? uc_q.pop_front() : 16'hxxxx)
      end
   end
   always @(negedge mclk) begin
      if (word_stb === 1'b1) begin
         `CHK(rx_word, (samp_q.size() > 0) ? samp_q.pop_front() : 16'hxxxx)
         // first word of a burst has no backlog ahead of it
         if (nseen > 0) begin
            `CHK(rx_gap, 16'h0010)
         end
         nseen++;
      end
   end
   // ---------------------------------------------------------------
   // drivers
   // ---------------------------------------------------------------
   task automatic req(input logic uc, input logic [15:0] w);
      int n;
      @(posedge sys_clk_i);
      if (uc) begin
         uc_req_valid_i <= 1'b1;
         uc_req_word_i <= w;
      end else begin
         bsp_req_valid_i <= 1'b1;
         bsp_req_word_i <= w;
      end
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (((uc ? uc_req_ready_o : bsp_req_ready_o) !== 1'b1) && n < 100);
      if (uc) begin
         uc_req_valid_i <= 1'b0;
      end else begin
         bsp_req_valid_i <= 1'b0;
      end
   endtask : req
   function automatic logic [1:0] pg(input logic uc);
      return uc ? page_reg[1:0] : page_reg[3:2];
   endfunction : pg
   task automatic wr(input logic uc, input logic [4:0] a, input logic [9:0] d);
      if (a == 5'h01) begin
         page_reg = d;
      end else if (a != 5'h00) begin
         mem[pg(uc)][a] = d;
      end
      req(uc, {d, a, 1'b0});
   endtask : wr
   task automatic rd(input logic uc, input logic [4:0] a);
      logic [31:0] r;
      logic [15:0] e;
      r = $urandom;
      e = {(a == 5'h00) ? 10'h000 : (a == 5'h01) ? page_reg : mem[pg(uc)][a], a, 1'b1};
      if (uc) begin
         uc_q.push_back(e);
      end else begin
         bsp_q.push_back(e);
      end
      req(uc, {r[9:0], a, 1'b1});
   endtask : rd
   task automatic put(input logic [14:0] s, input logic q, input logic keep);
      int n;
      @(posedge sys_clk_i);
      sample_valid_i <= 1'b1;
      sample_i <= s;
      sample_is_q_i <= q;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
         if (sample_ready_o !== 1'b1) begin
            saw_full = 1'b1;
         end
      end while (sample_ready_o !== 1'b1 && n < 5000);
      sample_valid_i <= 1'b0;
      if (keep) begin
         samp_q.push_back({s, q});
      end
   endtask : put
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] r;
      void'($urandom(32'h0000_ba83));
      {nrst_i, bsp_req_valid_i, uc_req_valid_i, burst_active_i, sample_valid_i} = 5'h00;
      {bsp_req_word_i, uc_req_word_i, sample_i, sample_is_q_i} = 48'h0000_0000_0000;
      clk_en_i = 1'b1;
      saw_full = 1'b0;
      page_reg = 10'h000;
      foreach (mem[p, a]) mem[p][a] = 10'h000;
      repeat (20) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      for (int a = 0; a < 32; a++) begin
         rd(a[0], a[4:0]);
      end
      // random pages, addresses and ports, read back on both ports
      for (int i = 0; i < 60; i++) begin
         r = $urandom;
         wr(r[20], 5'h01, {6'h00, r[3:0]});
         wr(r[21], 5'h02 + 5'(r[8:4] % 30), r[31:22]);
         rd(r[22], 5'h02 + 5'(r[8:4] % 30));
         rd(!r[22], 5'h02 + 5'(r[8:4] % 30));
      end
      wr(1'b0, 5'h00, 10'h3ff);
      wr(1'b1, 5'h00, 10'h2aa);
      for (int a = 0; a < 32; a++) begin
         rd(a[1], a[4:0]);
      end
      // a sample outside a burst must not be sent
      put(15'h7fff, 1'b1, 1'b0);
      @(posedge sys_clk_i);
      burst_active_i <= 1'b1;
      for (int i = 0; i < 24; i++) begin
         r = $urandom;
         put(r[14:0], i[0], 1'b1);
      end
      while (samp_q.size() != 0) @(posedge sys_clk_i);
      repeat (200) @(posedge sys_clk_i);
      burst_active_i <= 1'b0;
      `CHK(saw_full, 1'b1)
      `CHK(gap_dirty, 1'b0)
      `CHK(32'(nseen), 32'd24)
      `CHK(32'(bsp_q.size() + uc_q.size()), 32'd0)
      end_sim();
   end
endmodule : swa_serial_register_word_access_tb
`default_nettype wire
